// ===== include/ufe_pkg.sv
/*
  Constants for the serial port with framing-error check.
  Assumes a single 200 MHz clock and a plain register port.
*/
package ufe_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam logic [3:0] ADDR_SCTL = 4'h0;
  localparam logic [3:0] ADDR_TXDATA = 4'h1;
  localparam logic [3:0] ADDR_RXDATA = 4'h2;
  localparam logic [3:0] ADDR_PWR = 4'h3;
  localparam logic [3:0] ADDR_BAUD_TX = 4'h4;
  localparam logic [3:0] ADDR_BAUD_RX = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam int BIT_FE = 7;
  localparam int BIT_SM1 = 6;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TI = 1;
  localparam int BIT_RI = 0;
  localparam int BIT_FCS = 6;
  localparam logic [7:0] SCTL_RST = 8'h00;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h06C8;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_FE = 2;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } ufe_rx_e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_DONE = 3'b100
  } ufe_tx_e;
endpackage

// ===== rtl/ufe_uart.sv
/*
  Serial port, asynchronous modes 1..3, with framing-error check.
  Assumes rxd is synchronous to mclk and the register master never waits.
*/
// Function
// - The port is a full-duplex UART in asynchronous modes one, two and three.
// - Transmitter and receiver run at once, each with its own baud divider.
// - Framing check applies in modes one to three only.
// - Framing check is active only while the check-select bit in the power register is set.
// - With the check on, the stop-bit sample of every frame is examined.
// - A bad stop bit with the check on sets the framing error flag.
// - The framing error flag stays set until software or reset clears it.
// - With the check on, receive-done rises at the stop bit, not the last data bit.
// - The flag sits in bit 7 of the serial control register, shared with mode bit 0, seen only with check-select set.
// - Software clears the flag by writing zero; hardware never clears it.
module ufe_uart
  import ufe_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Interrupt
  output logic irq
);
  logic [7:0] sctl_ff;
  logic fe_ff;
  logic sm0_ff;
  logic fcs_ff;
  logic [7:0] pwr_ff;
  logic [15:0] btx_ff;
  logic [15:0] brx_ff;
  logic [2:0] ist_ff;
  logic [2:0] imask_ff;
  logic [7:0] rdata_ff;
  logic [7:0] rbuf_ff;
  ufe_rx_e rx_ff;
  ufe_tx_e tx_ff;
  logic [15:0] rcnt_ff;
  logic [3:0] rbit_ff;
  logic [8:0] rsh_ff;
  logic [15:0] tcnt_ff;
  logic [3:0] tbit_ff;
  logic [10:0] tsh_ff;
  logic txd_ff;

  // Decode of one register address
  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    return a == target;
  endfunction

  wire [1:0] mode = {sm0_ff, sctl_ff[BIT_SM1]};
  wire async_mode = (mode != 2'b00);
  wire check_on = fcs_ff && async_mode;
  wire nine_bit = mode[1];
  wire [3:0] nbits = nine_bit ? 4'd9 : 4'd8;
  wire sel_sctl = hit(addr, ADDR_SCTL);
  wire sel_tx = hit(addr, ADDR_TXDATA);
  wire sel_rx = hit(addr, ADDR_RXDATA);
  wire sel_pwr = hit(addr, ADDR_PWR);
  wire sel_btx = hit(addr, ADDR_BAUD_TX);
  wire sel_brx = hit(addr, ADDR_BAUD_RX);
  wire sel_ist = hit(addr, ADDR_IRQ_STAT);
  wire sel_imk = hit(addr, ADDR_IRQ_MASK);

  wire rtick = (rcnt_ff == 16'h0000);
  wire ttick = (tcnt_ff == 16'h0000);
  wire [15:0] half_rx = {1'b0, brx_ff[15:1]};

  // Receiver events
  wire rx_last_data = (rx_ff == RX_DATA) && rtick && (rbit_ff == nbits - 4'd1);
  wire rx_stop = (rx_ff == RX_STOP) && rtick;
  wire stop_bad = rx_stop && check_on && !rxd;
  wire rx_done = check_on ? rx_stop : rx_last_data;
  wire tx_done = (tx_ff == TX_DONE);
  // Ninth bit: still on the line without check, already shifted in at the stop sample
  wire rb8_in = check_on ? rsh_ff[8] : rxd;

  wire [7:0] sctl_rd = {fcs_ff ? fe_ff : sm0_ff, sctl_ff[6:0]};

  wire [7:0] rd_mux =
    sel_sctl ? sctl_rd :
    sel_rx ? rbuf_ff :
    sel_pwr ? {1'b0, fcs_ff, pwr_ff[5:0]} :
    sel_btx ? btx_ff[7:0] :
    sel_brx ? brx_ff[7:0] :
    sel_ist ? {5'h00, ist_ff} :
    sel_imk ? {5'h00, imask_ff} :
    8'h00;

  wire [2:0] ev = {stop_bad, tx_done, rx_done};

  // Software bits of the serial control register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sctl_ff[7:3] <= SCTL_RST[7:3];
    end else if (wr && sel_sctl) begin
      sctl_ff[6:3] <= wdata[6:3];
    end
  end

  // Receive-done and transmit-done flags; set wins over a clearing write
  wire [1:0] flag_set = {tx_done, rx_done};
  for (genvar i = 0; i < 2; i++) begin : g_flag
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        sctl_ff[i] <= SCTL_RST[i];
      end else if (flag_set[i]) begin
        sctl_ff[i] <= 1'b1;
      end else if (wr && sel_sctl) begin
        sctl_ff[i] <= wdata[i];
      end
    end
  end

  // Received ninth bit in modes two and three
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sctl_ff[BIT_RB8] <= SCTL_RST[BIT_RB8];
    end else if (rx_done && nine_bit) begin
      sctl_ff[BIT_RB8] <= rb8_in;
    end else if (wr && sel_sctl) begin
      sctl_ff[BIT_RB8] <= wdata[BIT_RB8];
    end
  end

  // Mode bit 0, written only while check select is clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sm0_ff <= 1'b0;
    end else if (wr && sel_sctl && !fcs_ff) begin
      sm0_ff <= wdata[BIT_FE];
    end
  end

  // Power register with check select
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fcs_ff <= 1'b0;
      pwr_ff <= PWR_RST;
    end else if (wr && sel_pwr) begin
      fcs_ff <= wdata[BIT_FCS];
      pwr_ff <= wdata;
    end
  end

  // Baud dividers, low byte writable; a write clears the high byte
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      btx_ff <= BAUD_RST;
      brx_ff <= BAUD_RST;
    end else begin
      if (wr && sel_btx) begin
        btx_ff <= {8'h00, wdata};
      end
      if (wr && sel_brx) begin
        brx_ff <= {8'h00, wdata};
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      imask_ff <= IRQ_RST;
    end else if (wr && sel_imk) begin
      imask_ff <= wdata[2:0];
    end
  end

  // Framing error flag: set wins over clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fe_ff <= 1'b0;
    end else if (stop_bad) begin
      fe_ff <= 1'b1;
    end else if (wr && sel_sctl && fcs_ff && !wdata[BIT_FE]) begin
      fe_ff <= 1'b0;
    end
  end

  // Interrupt status, one write-one-to-clear bit per event; set wins
  for (genvar i = 0; i < 3; i++) begin : g_ist
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        ist_ff[i] <= IRQ_RST[i];
      end else if (ev[i]) begin
        ist_ff[i] <= 1'b1;
      end else if (wr && sel_ist && wdata[i]) begin
        ist_ff[i] <= 1'b0;
      end
    end
  end

  // Reads return zero outside their cycle

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd ? rd_mux : 8'h00;
    end
  end

  // Receiver, own divider
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_ff <= RX_IDLE;
      rcnt_ff <= 16'h0000;
      rbit_ff <= 4'h0;
      rsh_ff <= 9'h000;
      rbuf_ff <= 8'h00;
    end else begin
      rcnt_ff <= rtick ? brx_ff : rcnt_ff - 16'd1;
      case (rx_ff)
        RX_IDLE: begin
          // Start edge: wait half a bit to sample mid-start
          if (async_mode && sctl_ff[BIT_REN] && !rxd) begin
            rx_ff <= RX_START;
            rcnt_ff <= half_rx;
          end
        end
        RX_START: begin
          if (rtick) begin
            rx_ff <= rxd ? RX_IDLE : RX_DATA;
            rbit_ff <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rtick) begin
            rsh_ff <= {rxd, rsh_ff[8:1]};
            rbit_ff <= rbit_ff + 4'd1;
            if (rbit_ff == nbits - 4'd1) begin
              rx_ff <= RX_STOP;
              rbuf_ff <= nine_bit ? rsh_ff[8:1] : {rxd, rsh_ff[8:2]};
            end
          end
        end
        RX_STOP: begin
          if (rtick) begin
            rx_ff <= RX_IDLE;
          end
        end
        default: rx_ff <= RX_IDLE;
      endcase
    end
  end

  // Transmitter, own divider
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_ff <= TX_IDLE;
      tcnt_ff <= 16'h0000;
      tbit_ff <= 4'h0;
      tsh_ff <= 11'h7FF;
      txd_ff <= 1'b1;
    end else begin
      tcnt_ff <= ttick ? btx_ff : tcnt_ff - 16'd1;
      case (tx_ff)
        TX_IDLE: begin
          txd_ff <= 1'b1;
          if (wr && sel_tx && async_mode) begin
            tx_ff <= TX_SHIFT;
            tcnt_ff <= btx_ff;
            // One tick past the stop bit keeps it a full bit time
            tbit_ff <= nbits + 4'd3;
            tsh_ff <= nine_bit ? {1'b1, sctl_ff[BIT_TB8], wdata, 1'b0} : {2'b11, wdata, 1'b0};
          end
        end
        TX_SHIFT: begin
          if (ttick) begin
            txd_ff <= tsh_ff[0];
            tsh_ff <= {1'b1, tsh_ff[10:1]};
            tbit_ff <= tbit_ff - 4'd1;
            if (tbit_ff == 4'd1) begin
              tx_ff <= TX_DONE;
            end
          end
        end
        TX_DONE: begin
          tx_ff <= TX_IDLE;
        end
        default: tx_ff <= TX_IDLE;
      endcase
    end
  end

  assign rdata = rdata_ff;
  assign txd = txd_ff;
  assign irq = |(ist_ff & imask_ff);
endmodule

// ===== verification/ufe_far_node.sv
/*
  Far serial node sending mode one frames on the receive line.
  Assumes the bench gives the bit time in mclk cycles.
*/
module ufe_far_node (
  // Clock
  input wire logic mclk,
  // Line
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic stop_ok, input int bt);
    logic [9:0] f;
    f = {stop_ok, d, 1'b0};
    for (int i = 0; i < 10 * bt; i++) begin
      @(posedge mclk);
      line <= f[i / bt];
    end
    @(posedge mclk);
    line <= 1'b1;
  endtask
endmodule

// ===== verification/ufe_uart_chk.sv
/*
  Port checker for the serial port with framing check.
  Assumes it is bound to every ufe_uart instance.
*/
module ufe_uart_chk
  import ufe_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Line and interrupt
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic chk_ff, mode0_ff, stop_bad_ff, rd_chk_ff;
  logic [2:0] mask_ff;
  wire logic sctl_rd = rd && addr == ADDR_SCTL;
  wire logic sctl_wr = wr && addr == ADDR_SCTL;
  wire logic pwr_wr = wr && addr == ADDR_PWR;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {chk_ff, mode0_ff, stop_bad_ff, rd_chk_ff, mask_ff} <= '0;
    end else begin
      rd_chk_ff <= sctl_rd && chk_ff;
      if (pwr_wr) chk_ff <= wdata[BIT_FCS];
      if (sctl_wr && !chk_ff) mode0_ff <= wdata[BIT_FE];
      if (wr && addr == ADDR_IRQ_MASK) mask_ff <= wdata[2:0];
      if (sctl_wr && chk_ff && !wdata[BIT_FE] || pwr_wr) stop_bad_ff <= 1'b0;
      else if (rd_chk_ff && rdata[BIT_FE]) stop_bad_ff <= 1'b1;
    end
  end
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside its cycle");
  a_unmapped_zero: assert property (rd && addr > ADDR_IRQ_MASK |=> rdata == 8'h00) else $error("unmapped read");
  a_flag_sticky: assert property (sctl_rd && chk_ff && stop_bad_ff |=> rdata[BIT_FE])
    else $error("error flag lost");
  a_mode_shared: assert property (sctl_rd && !chk_ff |=> rdata[BIT_FE] == $past(mode0_ff))
    else $error("mode bit wrong");
  a_select_readback: assert property (rd && addr == ADDR_PWR |=> rdata[BIT_FCS] == $past(chk_ff))
    else $error("check select wrong");
  a_mask_readback: assert property (rd && addr == ADDR_IRQ_MASK |=> rdata == {5'h00, $past(mask_ff)})
    else $error("mask wrong");
  a_irq_masked: assert property (mask_ff == 3'h0 |-> !irq) else $error("masked interrupt");
  a_reset_idle: assert property ($rose(rst_n) |-> txd && !irq) else $error("not idle after reset");
  c_flag_seen: cover property (stop_bad_ff);
  c_irq_rise: cover property ($rose(irq));
  c_mode_read: cover property (sctl_rd && !chk_ff);
endmodule
bind ufe_uart ufe_uart_chk u_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));

// ===== verification/ufe_uart_tb.sv
/*
  Self-checking bench for the serial port with framing check.
  Assumes the far node model and the bound checker.
*/
module ufe_uart_tb
  import ufe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BT = 4;
  logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, d, rdata;
  logic rxd, txd, irq;
  logic [7:0] exp_q[$];
  int errors = 0, checks_done = 0;
  integer seed = 13;
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  ufe_uart u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rxd(rxd), .txd(txd), .irq(irq));
  ufe_far_node u_far (.mclk(mclk), .line(rxd));
  task automatic conclude();
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write, or read with expected data queued
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    if (!w) exp_q.push_back(v);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic frame(input logic stop_ok, input logic want);
    d = 8'($random(seed));
    u_far.send(d, stop_ok, BT);
    for (int i = 0; i < 2 * BT && irq !== want; i++) @(posedge mclk);
    check({7'h00, irq}, {7'h00, want});
    if (irq !== want) conclude();
  endtask
  // Sample one transmitted mode three frame at mid-bit
  task automatic tx_frame(input logic [7:0] v);
    logic [10:0] got;
    int n;
    got = 11'h000;
    n = 0;
    while (txd !== 1'b0 && n < 64) begin
      @(posedge mclk);
      n++;
    end
    if (n == 64) begin
      errors++;
      conclude();
    end
    repeat (BT / 2) @(posedge mclk);
    for (int i = 0; i < 11; i++) begin
      got[i] = txd;
      repeat (BT) @(posedge mclk);
    end
    check(got[8:1], v);
    check({5'h00, got[10:9], got[0]}, 8'h04);
  endtask
  always @(posedge mclk) begin
    if (rd_q && exp_q.size() > 0) check(rdata, exp_q.pop_front());
    rd_q = rd;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, ADDR_SCTL, SCTL_RST);
    bus(1'b0, 4'hF, 8'h00);
    bus(1'b0, ADDR_BAUD_RX, BAUD_RST[7:0]);
    bus(1'b1, ADDR_PWR, 8'h40);
    bus(1'b1, ADDR_BAUD_RX, 8'h03);
    bus(1'b1, ADDR_IRQ_MASK, 8'h07);
    bus(1'b1, ADDR_SCTL, 8'h50);
    bus(1'b0, ADDR_PWR, 8'h40);
    bus(1'b0, ADDR_IRQ_MASK, 8'h07);
    frame(1'b0, 1'b1);
    bus(1'b0, ADDR_SCTL, 8'hD1);
    bus(1'b0, ADDR_RXDATA, d);
    bus(1'b0, ADDR_IRQ_STAT, 8'h05);
    frame(1'b1, 1'b1);
    bus(1'b0, ADDR_SCTL, 8'hD1);
    bus(1'b1, ADDR_SCTL, 8'h50);
    bus(1'b1, ADDR_IRQ_STAT, 8'h07);
    bus(1'b1, ADDR_IRQ_MASK, 8'h00);
    bus(1'b0, ADDR_SCTL, 8'h50);
    frame(1'b0, 1'b0);
    bus(1'b0, ADDR_IRQ_STAT, 8'h05);
    bus(1'b1, ADDR_IRQ_MASK, 8'h07);
    check({7'h00, irq}, 8'h01);
    bus(1'b1, ADDR_SCTL, 8'h50);
    bus(1'b1, ADDR_IRQ_STAT, 8'h07);
    check({7'h00, irq}, 8'h00);
    bus(1'b1, ADDR_PWR, 8'h00);
    frame(1'b0, 1'b1);
    bus(1'b0, ADDR_SCTL, 8'h51);
    bus(1'b0, ADDR_IRQ_STAT, 8'h01);
    bus(1'b1, ADDR_SCTL, 8'hD0);
    bus(1'b0, ADDR_SCTL, 8'hD0);
    bus(1'b1, ADDR_PWR, 8'h40);
    bus(1'b0, ADDR_SCTL, 8'h50);
    bus(1'b1, ADDR_BAUD_TX, 8'h03);
    d = 8'($random(seed));
    bus(1'b1, ADDR_TXDATA, d);
    tx_frame(d);
    bus(1'b0, ADDR_IRQ_STAT, 8'h03);
    bus(1'b0, ADDR_SCTL, 8'h52);
    conclude();
  end
endmodule
